/* mls_chk.sv */
// Concurrent checks on the ports of the lane sequencer.
`timescale 1ns/1ps
module mls_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclk_out,
  input wire logic select_n,
  input mls_pkg::mls_lanes_t lanes
);
  import mls_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_oe_span;
    lanes.oe_n inside {8'hff, 8'hfe, 8'hfc, 8'hf0, 8'h00};
  endproperty
  a_oe_span: assert property (p_oe_span)
    else $error("lane enables not contiguous from lane 0");
  property p_idle_release;
    select_n |-> lanes.oe_n == 8'hff;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("lane driven while target not selected");
  property p_sclk_idle;
    select_n |-> !sclk_out;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock moves outside a frame");
  // A full receive queue would freeze the clock low; the bench never lets it fill.
  property p_sclk_high;
    $rose(sclk_out) |-> sclk_out [*8] ##1 !sclk_out;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high half is not 8 cycles");
  property p_data_hold;
    sclk_out && $past(sclk_out) |-> $stable(lanes.data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("lane data changed while serial clock high");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2];
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write response repeated too soon");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read response repeated too soon");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data not one cycle after address");
endmodule

bind mls_sequencer mls_chk i_mls_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sclk_out(sclk_out), .select_n(select_n), .lanes(lanes));

/* mls_defines.svh */
// Register offsets, field positions, reset values and timing counts of the lane sequencer.
`ifndef MLS_DEFINES_SVH
`define MLS_DEFINES_SVH

`define MLS_OFS_MAIN_CONTROL 8'h00
`define MLS_OFS_SECOND_CONTROL 8'h04
`define MLS_OFS_MULTILANE_CONTROL 8'h08
`define MLS_OFS_DATA_PORT 8'h0c
`define MLS_OFS_STATUS 8'h10

`define MLS_MC_LANE_FORMAT 1:0
`define MLS_MC_READ 2
`define MLS_MC_ENABLE 3
`define MLS_SC_FRAME_COUNT 15:0
`define MLS_ML_PHASE_FORMAT 1:0
`define MLS_ML_INST_LEN 3:2
`define MLS_ML_ADDR_LEN 7:4
`define MLS_ML_WAIT 12:8

`define MLS_RST_MAIN_CONTROL 32'h0000_0000
`define MLS_RST_SECOND_CONTROL 32'h0000_0000
`define MLS_RST_MULTILANE_CONTROL 32'h0000_0000

`define MLS_CLK_PERIOD_NS 5
`define MLS_SCLK_PERIOD_NS 80
`define MLS_HALF_CYCLES ((`MLS_SCLK_PERIOD_NS / `MLS_CLK_PERIOD_NS) / 2)
`define MLS_FRAME_BITS 8
`define MLS_FIFO_DEPTH 16

`define MLS_RESP_OKAY 2'b00
`define MLS_RESP_SLVERR 2'b10

`endif

/* mls_fifo.sv */
// Queue with a registered read port, parameterised in width and depth.
`timescale 1ns/1ps
module mls_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] mem_cnt_ff;
  logic [CW-1:0] count_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic out_valid_ff;
  logic push;
  logic pop;
  logic load;

  // The output register counts toward the depth, so full is honest at DEPTH words.
  assign in_ready = count_ff < CW'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = out_valid_ff && out_ready;
  assign load = (mem_cnt_ff != '0) && (!out_valid_ff || pop);
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign count = count_ff;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      mem_cnt_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      mem_cnt_ff <= mem_cnt_ff + CW'(push) - CW'(load);
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (load) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (pop) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule

/* mls_pkg.sv */
// Types shared by the lane sequencer, its checker, the serial target model and the bench.
package mls_pkg;

  typedef enum {
    ST_IDLE,
    ST_START,
    ST_INST,
    ST_ADDR,
    ST_WAIT,
    ST_TX,
    ST_RX,
    ST_DONE
  } mls_state_t;

  typedef struct packed {
    logic [1:0] lane_format;
    logic read_mode;
    logic [15:0] frame_count;
    logic [1:0] phase_format;
    logic [1:0] inst_len;
    logic [3:0] addr_len;
    logic [4:0] wait_cycles;
  } mls_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe_n;
  } mls_lanes_t;

endpackage

/* mls_sequencer.sv */
// Multi-lane serial phase sequencer with an AXI4-Lite register slave.
// Function
// - Phase format 01b: instruction on one lane, address on all selected lanes.
// - Phase format 10b: instruction and address on all lanes, then data.
// - Instruction-only transfers are supported; with 10b it uses all lanes.
// - Highest lane N is 7, 3 or 1 for lane format 11b, 10b, 01b.
// - A read runs instruction, address, wait gap, then received data.
// - Exactly the programmed number of serial clock wait periods, zero allowed.
// - Read sends instruction and address once, receives frame count plus one frames, then deselects.
// - Read with 00b: instruction and address single lane, then wait, multi-lane data.
// - Lane format field sets the data lane format of every read.
// - A write starts only once instruction and address are queued.
// - A write sends instruction and address once, then streams until queue empty.
// - Instruction length 0, 4, 8 or 16 bits; one queue entry each.
// - Standard lane format sends every phase on one lane, ignoring phase format.
`timescale 1ns/1ps
`include "mls_defines.svh"
module mls_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sclk_out,
  output logic select_n,
  output mls_pkg::mls_lanes_t lanes,
  input wire logic [7:0] lane_in
);
  import mls_pkg::*;

  localparam int CW = $clog2(`MLS_FIFO_DEPTH + 1);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [3:0] lane_width(input logic [1:0] lf);
    case (lf)
      2'b01: return 4'h2;
      2'b10: return 4'h4;
      2'b11: return 4'h8;
      default: return 4'h1;
    endcase
  endfunction

  function automatic logic [5:0] inst_bits(input logic [1:0] code);
    case (code)
      2'b01: return 6'h04;
      2'b10: return 6'h08;
      2'b11: return 6'h10;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic [5:0] addr_bits(input logic [3:0] len);
    // Only one queue word carries the address, so widths beyond 32 bits clamp.
    return (len > 4'h8) ? 6'h20 : {len, 2'b00};
  endfunction

  // Register bus.
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] main_ctrl_ff, second_ctrl_ff, ml_ctrl_ff;
  logic do_write, rd_take, w_is_data, w_mapped, r_mapped;
  logic [31:0] rd_mux, status_word;

  // Queues.
  logic tx_in_ready, tx_out_valid, tx_pop;
  logic [31:0] tx_out_data;
  logic [CW-1:0] tx_count;
  logic rx_in_ready, rx_out_valid, rx_pop;
  logic [31:0] rx_out_data;
  logic [CW-1:0] rx_count;

  // Serial engine.
  mls_state_t state_ff, nxt_state;
  mls_cfg_t cfg_reg, cfg_ff;
  logic [31:0] shift_ff;
  logic [5:0] bits_ff;
  logic [4:0] wait_ff;
  logic [16:0] frames_ff;
  logic [7:0] acc_ff;
  logic rx_push_ff;
  logic [31:0] rx_word_ff;
  logic sclk_ff, select_n_ff;
  mls_lanes_t lanes_ff, nxt_lanes;
  logic [4:0] div_ff;
  logic [7:0] rx_meta_ff, rx_sync_ff;
  logic half_tick, active, stall, tick, rise, fall, phase_end, enter, start_ok;
  logic [3:0] lw, inst_w, addr_w, cur_w;
  logic [1:0] need;
  logic [7:0] in_bits;

  assign w_is_data = awaddr_ff == `MLS_OFS_DATA_PORT;
  assign w_mapped = (awaddr_ff == `MLS_OFS_MAIN_CONTROL) || (awaddr_ff == `MLS_OFS_SECOND_CONTROL) ||
                    (awaddr_ff == `MLS_OFS_MULTILANE_CONTROL) || w_is_data ||
                    (awaddr_ff == `MLS_OFS_STATUS);
  // A data port write waits for room in the transmit queue; this is the back-pressure.
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff && (!w_is_data || tx_in_ready);
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign rd_take = s_axi_arvalid && !rvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign rx_pop = rd_take && (s_axi_araddr == `MLS_OFS_DATA_PORT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `MLS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= w_mapped ? `MLS_RESP_OKAY : `MLS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_ctrl_ff <= `MLS_RST_MAIN_CONTROL;
      second_ctrl_ff <= `MLS_RST_SECOND_CONTROL;
      ml_ctrl_ff <= `MLS_RST_MULTILANE_CONTROL;
    end else if (do_write) begin
      case (awaddr_ff)
        `MLS_OFS_MAIN_CONTROL: main_ctrl_ff <= merge(main_ctrl_ff, wdata_ff, wstrb_ff);
        `MLS_OFS_SECOND_CONTROL: second_ctrl_ff <= merge(second_ctrl_ff, wdata_ff, wstrb_ff);
        `MLS_OFS_MULTILANE_CONTROL: ml_ctrl_ff <= merge(ml_ctrl_ff, wdata_ff, wstrb_ff);
        default: ;
      endcase
    end
  end

  assign status_word = {16'h0000, 3'b000, rx_count, 3'b000, tx_count} |
                       {31'h0, state_ff != ST_IDLE} << 31;
  assign r_mapped = (s_axi_araddr == `MLS_OFS_MAIN_CONTROL) ||
                    (s_axi_araddr == `MLS_OFS_SECOND_CONTROL) ||
                    (s_axi_araddr == `MLS_OFS_MULTILANE_CONTROL) ||
                    (s_axi_araddr == `MLS_OFS_DATA_PORT) || (s_axi_araddr == `MLS_OFS_STATUS);

  always_comb begin
    case (s_axi_araddr)
      `MLS_OFS_MAIN_CONTROL: rd_mux = main_ctrl_ff & 32'h0000_000f;
      `MLS_OFS_SECOND_CONTROL: rd_mux = second_ctrl_ff & 32'h0000_ffff;
      `MLS_OFS_MULTILANE_CONTROL: rd_mux = ml_ctrl_ff & 32'h0000_1fff;
      `MLS_OFS_DATA_PORT: rd_mux = rx_out_valid ? rx_out_data : 32'h0000_0000;
      `MLS_OFS_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `MLS_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= r_mapped ? `MLS_RESP_OKAY : `MLS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  mls_fifo #(.WIDTH(32), .DEPTH(`MLS_FIFO_DEPTH)) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(do_write && w_is_data),
    .in_ready(tx_in_ready),
    .in_data(wdata_ff),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_out_data),
    .count(tx_count)
  );

  mls_fifo #(.WIDTH(32), .DEPTH(`MLS_FIFO_DEPTH)) u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rx_push_ff),
    .in_ready(rx_in_ready),
    .in_data(rx_word_ff),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_out_data),
    .count(rx_count)
  );

  // Serial engine: configuration is frozen at start so software may reprogram mid-transfer.
  assign cfg_reg = '{lane_format: main_ctrl_ff[`MLS_MC_LANE_FORMAT],
                     read_mode: main_ctrl_ff[`MLS_MC_READ],
                     frame_count: second_ctrl_ff[`MLS_SC_FRAME_COUNT],
                     phase_format: ml_ctrl_ff[`MLS_ML_PHASE_FORMAT],
                     inst_len: ml_ctrl_ff[`MLS_ML_INST_LEN],
                     addr_len: ml_ctrl_ff[`MLS_ML_ADDR_LEN],
                     wait_cycles: ml_ctrl_ff[`MLS_ML_WAIT]};

  assign lw = lane_width(cfg_ff.lane_format);
  // Standard lane format gives lw of one, so the phase format has no effect.
  assign inst_w = (cfg_ff.phase_format == 2'b10) ? lw : 4'h1;
  assign addr_w = (cfg_ff.phase_format == 2'b01 || cfg_ff.phase_format == 2'b10) ? lw : 4'h1;

  always_comb begin
    case (state_ff)
      ST_INST: cur_w = inst_w;
      ST_ADDR: cur_w = addr_w;
      default: cur_w = lw;
    endcase
  end

  assign need = {1'b0, cfg_reg.inst_len != 2'b00} + {1'b0, cfg_reg.addr_len != 4'h0};
  assign start_ok = main_ctrl_ff[`MLS_MC_ENABLE] &&
                    (tx_count >= ((need == 2'b00) ? CW'(1) : CW'(need)));
  assign active = (state_ff == ST_INST) || (state_ff == ST_ADDR) || (state_ff == ST_WAIT) ||
                  (state_ff == ST_TX) || (state_ff == ST_RX);
  // A full receive queue freezes the serial clock rather than dropping a frame.
  assign stall = rx_push_ff && !rx_in_ready;
  assign half_tick = div_ff == 5'(`MLS_HALF_CYCLES - 1);
  assign tick = half_tick && active && !stall;
  assign rise = tick && !sclk_ff;
  assign fall = tick && sclk_ff;
  assign phase_end = (state_ff == ST_WAIT) ? (wait_ff == 5'h01) : (bits_ff <= {2'b00, cur_w});
  assign enter = (state_ff == ST_START) || (fall && phase_end);

  always_comb begin
    nxt_state = ST_DONE;
    case (state_ff)
      ST_START: nxt_state = (cfg_ff.inst_len != 2'b00) ? ST_INST : ST_INST;
      ST_RX: nxt_state = (frames_ff > 17'h00001) ? ST_RX : ST_DONE;
      ST_WAIT: nxt_state = ST_RX;
      ST_TX: nxt_state = tx_out_valid ? ST_TX : ST_DONE;
      default: nxt_state = ST_DONE;
    endcase
    if (state_ff == ST_START || state_ff == ST_INST || state_ff == ST_ADDR) begin
      // Instruction, address, wait (reads only), data in that order, skipping empty phases.
      if (state_ff == ST_START && cfg_ff.inst_len != 2'b00) begin
        nxt_state = ST_INST;
      end else if (state_ff != ST_ADDR && cfg_ff.addr_len != 4'h0) begin
        nxt_state = ST_ADDR;
      end else if (cfg_ff.read_mode) begin
        nxt_state = (cfg_ff.wait_cycles != 5'h00) ? ST_WAIT : ST_RX;
      end else begin
        nxt_state = tx_out_valid ? ST_TX : ST_DONE;
      end
    end
  end

  // Each instruction and address takes one queue word; a bare read pops one dummy word.
  assign tx_pop = (enter && (nxt_state == ST_INST || nxt_state == ST_ADDR ||
                  nxt_state == ST_TX)) ||
                  (state_ff == ST_START && cfg_ff.read_mode && cfg_ff.inst_len == 2'b00 &&
                  cfg_ff.addr_len == 4'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      cfg_ff <= '0;
      shift_ff <= 32'h0000_0000;
      bits_ff <= 6'h00;
      wait_ff <= 5'h00;
      frames_ff <= 17'h00000;
    end else if (state_ff == ST_IDLE) begin
      if (start_ok) begin
        state_ff <= ST_START;
        cfg_ff <= cfg_reg;
      end
    end else if (state_ff == ST_DONE) begin
      state_ff <= ST_IDLE;
    end else if (enter) begin
      state_ff <= nxt_state;
      if (state_ff == ST_START) begin
        frames_ff <= {1'b0, cfg_ff.frame_count} + 17'h00001;
      end else if (state_ff == ST_RX) begin
        frames_ff <= frames_ff - 17'h00001;
      end
      case (nxt_state)
        ST_INST: begin
          shift_ff <= tx_out_data << (6'h20 - inst_bits(cfg_ff.inst_len));
          bits_ff <= inst_bits(cfg_ff.inst_len);
        end
        ST_ADDR: begin
          shift_ff <= tx_out_data << (6'h20 - addr_bits(cfg_ff.addr_len));
          bits_ff <= addr_bits(cfg_ff.addr_len);
        end
        ST_TX: begin
          shift_ff <= {tx_out_data[7:0], 24'h000000};
          bits_ff <= 6'(`MLS_FRAME_BITS);
        end
        ST_RX: bits_ff <= 6'(`MLS_FRAME_BITS);
        ST_WAIT: wait_ff <= cfg_ff.wait_cycles;
        default: ;
      endcase
    end else if (fall) begin
      shift_ff <= shift_ff << cur_w;
      bits_ff <= bits_ff - {2'b00, cur_w};
      wait_ff <= wait_ff - 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 5'h00;
      sclk_ff <= 1'b0;
      select_n_ff <= 1'b1;
    end else begin
      div_ff <= (half_tick || !active) ? 5'h00 : div_ff + 5'h01;
      if (!active) begin
        sclk_ff <= 1'b0;
      end else if (tick) begin
        sclk_ff <= !sclk_ff;
      end
      select_n_ff <= !active;
    end
  end

  // Two flip-flops before the lane inputs are read; the sample lands well inside a half period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_ff <= 8'h00;
      rx_sync_ff <= 8'h00;
    end else begin
      rx_meta_ff <= lane_in;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  always_comb begin
    case (lw)
      4'h2: in_bits = {6'h00, rx_sync_ff[1:0]};
      4'h4: in_bits = {4'h0, rx_sync_ff[3:0]};
      4'h8: in_bits = rx_sync_ff;
      default: in_bits = {7'h00, rx_sync_ff[1]};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= 8'h00;
      rx_push_ff <= 1'b0;
      rx_word_ff <= 32'h0000_0000;
    end else begin
      if (rise && state_ff == ST_RX) begin
        acc_ff <= (acc_ff << lw) | in_bits;
      end
      if (fall && phase_end && state_ff == ST_RX) begin
        rx_push_ff <= 1'b1;
        rx_word_ff <= {24'h000000, acc_ff};
      end else if (rx_in_ready) begin
        rx_push_ff <= 1'b0;
      end
    end
  end

  // Lane i carries shift bit 32-w+i, so the highest active lane holds the most significant bit.
  always_comb begin
    nxt_lanes.data = 8'h00;
    nxt_lanes.oe_n = 8'hff;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(cur_w) && (state_ff == ST_INST || state_ff == ST_ADDR ||
          state_ff == ST_TX)) begin
        nxt_lanes.data[i] = shift_ff[32 - int'(cur_w) + i];
        nxt_lanes.oe_n[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lanes_ff <= '{data: 8'h00, oe_n: 8'hff};
    end else begin
      lanes_ff <= nxt_lanes;
    end
  end

  assign lanes = lanes_ff;
  assign sclk_out = sclk_ff;
  assign select_n = select_n_ff;
endmodule

/* mls_target.sv */
// Behavioural serial target that answers reads on the released lanes.
`timescale 1ns/1ps
module mls_target (
  input wire logic aclk,
  input wire logic sclk_out,
  input wire logic select_n,
  input mls_pkg::mls_lanes_t lanes,
  input wire logic [3:0] width,
  input wire logic [4:0] wait_n,
  input wire logic [7:0] base,
  output logic [7:0] drive
);
  import mls_pkg::*;
  logic [7:0] mdrv = 8'h5a;
  logic sp = 0;
  logic rel = 0;
  int r = 0;
  assign drive = mdrv;

  // Frame bytes count up from base; the top bits of each byte go out first.
  function automatic logic [7:0] chunk(input int idx);
    logic [7:0] b;
    b = base + 8'(idx / (8 / width));
    b = b << (width * (idx % (8 / width)));
    b = b >> (8 - width);
    return (width == 1) ? {8{b[0]}} : b;
  endfunction

  // Outside the data phase the lanes toggle so that a stale value never passes.
  always @(posedge aclk) begin
    sp <= sclk_out;
    rel <= !select_n && &lanes.oe_n;
    if (select_n || !(&lanes.oe_n)) begin
      r <= 0;
      mdrv <= ~mdrv;
    end else begin
      if (sclk_out && !sp)
        r <= r + 1;
      if (!rel || (!sclk_out && sp))
        mdrv <= (r >= wait_n) ? chunk(r - wait_n) : ~mdrv;
    end
  end
endmodule

/* tb.sv */
// Self-checking bench for the lane sequencer with a serial target model.
`timescale 1ns/1ps
`include "mls_defines.svh"
module tb;
  import mls_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, lane_in, drive, mbase = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] mwidth = 1;
  logic [4:0] mwait = 0;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0, sclk_out, select_n, sp = 0;
  logic [1:0] bresp, rresp;
  mls_lanes_t lanes;
  int failures = 0, n_tests = 0;
  int exp_q[$];
  logic [11:0] got_q[$];

  always #2.5 aclk = ~aclk;
  assign lane_in = (lanes.oe_n & drive) | (~lanes.oe_n & lanes.data);

  mls_sequencer i_mls_sequencer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sclk_out(sclk_out), .select_n(select_n), .lanes(lanes), .lane_in(lane_in));
  mls_target i_mls_target (.aclk(aclk), .sclk_out(sclk_out), .select_n(select_n),
    .lanes(lanes), .width(mwidth), .wait_n(mwait), .base(mbase), .drive(drive));

  // Each rising serial edge logs the active lane count and the driven bits.
  always @(posedge aclk) begin
    sp <= sclk_out;
    if (sclk_out && !sp && !select_n)
      got_q.push_back({4'(8 - $countones(lanes.oe_n)), lanes.data & ~lanes.oe_n});
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    logic ta, tw, hb;
    t = 0;
    hb = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!hb && t < 500) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      t++;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (hb) bready <= 0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    logic ta, hr;
    t = 0;
    hr = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!hr && t < 500) begin
      @(negedge aclk);
      ta = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      t++;
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (hr) rready <= 0;
    end
  endtask

  task automatic add(input int v, input int nb, input int w);
    for (int k = nb - w; k >= 0; k -= w)
      exp_q.push_back((w << 8) | ((v >> k) & ((1 << w) - 1)));
  endtask

  task automatic fin();
    int t;
    t = 0;
    while (select_n === 1'b1 && t < 400) begin
      @(posedge aclk);
      t++;
    end
    while (select_n !== 1'b1 && t < 8000) begin
      @(posedge aclk);
      t++;
    end
    repeat (4) @(posedge aclk);
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    exp_q.delete();
    got_q.delete();
  endtask

  task automatic run(input int rdm, input int lf, input int pf);
    int w, il, al, nd, wt, fc, v;
    logic [1:0] rs;
    logic [31:0] q;
    w = 1 << lf;
    al = 2 * ($urandom % 5);
    // A read with neither instruction nor address pops one dummy word.
    il = (rdm && al == 0 && $urandom % 2) ? 0 : 2 + $urandom % 2;
    nd = (al == 0 || rdm) ? 0 : 1 + $urandom % 3;
    wt = $urandom % 4;
    fc = $urandom % 3;
    mwidth <= 4'(w);
    mwait <= 5'(wt);
    mbase <= 8'($urandom);
    wr(`MLS_OFS_MULTILANE_CONTROL, 32'(wt << 8 | al << 4 | il << 2 | pf), rs);
    wr(`MLS_OFS_SECOND_CONTROL, 32'(fc), rs);
    wr(`MLS_OFS_MAIN_CONTROL, 32'(8 | rdm << 2 | lf), rs);
    v = $urandom;
    add(v, il ? 8 << (il - 2) : 0, (lf > 0 && pf == 2) ? w : 1);
    wr(`MLS_OFS_DATA_PORT, v, rs);
    if (al > 0) begin
      repeat (30) @(posedge aclk);
      chk(select_n, 1'b1);
      v = $urandom;
      add(v, al * 4, (lf > 0 && pf > 0) ? w : 1);
      wr(`MLS_OFS_DATA_PORT, v, rs);
    end
    repeat (nd) begin
      v = $urandom;
      add(v & 255, 8, w);
      wr(`MLS_OFS_DATA_PORT, v, rs);
    end
    if (rdm) repeat (wt + 8 / w * (fc + 1)) exp_q.push_back(0);
    fin();
    for (int i = 0; rdm && i <= fc; i++) begin
      rd(`MLS_OFS_DATA_PORT, q, rs);
      chk(q[7:0], 8'(mbase + i));
    end
    $display("test done: read %0d lanes %0d phases %0d", rdm, lf, pf);
  endtask

  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    logic [7:0] offs[4];
    logic [31:0] q;
    logic [1:0] rs;
    int v;
    offs = '{8'h00, 8'h04, 8'h08, 8'h20};
    void'($urandom(32'h6d3ae948));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], q, rs);
      chk(q, 32'h0);
      chk(rs, i == 3 ? `MLS_RESP_SLVERR : `MLS_RESP_OKAY);
    end
    wr(8'h20, 32'h1, rs);
    chk(rs, `MLS_RESP_SLVERR);
    $display("test done: reset values and unmapped access");
    for (int r = 0; r < 2; r++)
      for (int lf = 0; lf < 4; lf++)
        for (int pf = 0; pf < 3; pf++)
          run(r, lf, pf);
    // Fill the transmit queue with the engine off, then let one write drain it.
    wr(`MLS_OFS_MULTILANE_CONTROL, 32'ha, rs);
    wr(`MLS_OFS_MAIN_CONTROL, 32'h2, rs);
    mwidth <= 4'h4;
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      add(v & 255, 8, 4);
      wr(`MLS_OFS_DATA_PORT, v, rs);
    end
    rd(`MLS_OFS_STATUS, q, rs);
    chk(q[4:0], 5'h10);
    wr(`MLS_OFS_MAIN_CONTROL, 32'ha, rs);
    fin();
    rd(`MLS_OFS_STATUS, q, rs);
    chk(q[4:0], 5'h00);
    $display("test done: full queue drained");
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge aclk);
    failures++;
    finish_test();
  end
endmodule
